// *** common/scpi_map.svh ***
// Character codes, tree sizes and buffer depths of the header path parser
// Behaviour
// - Path returns to root at reset, device clear, terminator and root specifier.
// - Headers inside a unit are joined by colons; each moves the path deeper.
// - After a leaf and semicolon, the next header is looked up among siblings.
// - Omitted optional headers are assumed and the full command is executed.
// - Path rests at the parent of the last header actually given.
// - Subsystems under the optional source header are reachable straight from root.
// - A colon opening a unit resets the path to the root.
// - Root-level headers need no leading colon while the path is at the root.
// - Asterisk common commands leave the active path untouched.
// - No search beyond the current path level is made, except into the source subsystems from root.
// - A new message while response data is unread raises query interrupted.
// - Units of a compound message are split at each semicolon before the first error; the rest is skipped.
// - Header letters are matched without regard to case.
// - Each header matches in its long form or its short form.
// - A question mark after the last header marks the unit as a query.
// - A unit is a header, optionally a space, then a parameter.
// - A message is one or more units closed by a terminator.
// - Terminator is a newline, an end-of-message flag, or both.
// - Only ASCII characters are accepted; others are errors.
`ifndef SCPI_MAP_SVH
`define SCPI_MAP_SVH
`define CH_NL       8'h0a
`define CH_SPACE    8'h20
`define CH_STAR     8'h2a
`define CH_COLON    8'h3a
`define CH_SEMI     8'h3b
`define CH_QUERY    8'h3f
`define CH_LOW_A    8'h61
`define CH_LOW_Z    8'h7a
`define CASE_BIT    8'h20
`define KEY_CHARS   12
`define NODE_W      5
`define NODE_COUNT  20
`define ROOT_NODE   5'h00
`define SRC_NODE    5'h01
`define FIFO_DEPTH  32
`endif

// *** common/scpi_pkg.sv ***
// Shared types of the header path parser
`include "scpi_map.svh"
package scpi_pkg;
   typedef enum logic [1:0] {ST_START, ST_HEADER, ST_PARAM, ST_SKIP} parse_state_t;
   typedef struct packed {
      logic [`NODE_W-1:0]      parent;
      logic [8*`KEY_CHARS-1:0] key;
      logic [3:0]              long_len;
      logic [3:0]              short_len;
      logic                    exec;
      logic [`NODE_W-1:0]      dflt;
   } node_t;
endpackage : scpi_pkg

// *** src/byte_fifo.sv ***
// Character FIFO with valid and ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             wr_valid,
   output logic                  wr_ready,
   output logic [WIDTH-1:0]      rd_data,
   output logic                  rd_valid,
   input  wire logic             rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             ready_reg;
   logic             push;
   logic             pop;

   assign push     = wr_valid & ready_reg;
   assign pop      = rd_valid & rd_ready;
   assign rd_valid = (count_reg != '0);
   assign rd_data  = mem[rd_ptr_reg];
   assign wr_ready = ready_reg;

   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
         ready_reg  <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         ready_reg <= (count_next != (AW+1)'(DEPTH));
      end
   end
endmodule : byte_fifo

// *** src/scpi_header_path_parser.sv ***
// Program message parser tracking the active header path of the command tree
`timescale 1ns/10ps
`include "scpi_map.svh"
module scpi_header_path_parser (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic [7:0]        in_data,
   input  wire logic              in_eom,
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire logic              dev_clear,
   input  wire logic              resp_pending,
   input  wire logic              out_ready,
   output logic                   unit_valid,
   output logic [`NODE_W-1:0]     unit_node,
   output logic                   unit_query,
   output logic                   unit_common,
   output logic [31:0]            unit_key,
   output logic                   param_valid,
   output logic [7:0]             param_data,
   output logic                   msg_end,
   output logic                   cmd_error,
   output logic                   query_interrupted,
   output logic [`NODE_W-1:0]     path_node
);
   localparam int KEYW = 8*`KEY_CHARS;

   logic [8:0]                 fifo_data;
   logic                       fifo_valid;
   logic                       step;
   logic [7:0]                 ch;
   logic [7:0]                 ch_up;
   logic                       is_term;
   logic                       is_delim;
   scpi_pkg::parse_state_t     state_reg;
   scpi_pkg::parse_state_t     state_next;
   logic [`NODE_W-1:0]         path_reg;
   logic [`NODE_W-1:0]         path_next;
   logic [KEYW-1:0]            key_reg;
   logic [KEYW-1:0]            key_next;
   logic [KEYW-1:0]            key_now;
   logic [3:0]                 len_reg;
   logic [3:0]                 len_next;
   logic [3:0]                 len_now;
   logic [`NODE_W-1:0]         last_reg;
   logic [`NODE_W-1:0]         last_next;
   logic                       query_reg;
   logic                       query_next;
   logic                       common_reg;
   logic                       common_next;
   logic                       pseen_reg;
   logic                       pseen_next;
   logic                       msg_start_reg;
   logic                       msg_start_next;
   logic                       match_ok;
   logic [`NODE_W-1:0]         match_id;
   scpi_pkg::node_t            scan_nd;
   scpi_pkg::node_t            last_nd;
   logic [`NODE_W-1:0]         last_id;
   logic [`NODE_W-1:0]         exec_id;
   logic                       exec_ok;
   logic                       hdr_ok;
   logic                       emit;
   logic                       err;
   logic                       qint;
   logic                       pemit;

   // Command tree: parent, long keyword, long and short lengths, executable, default child
   function automatic scpi_pkg::node_t node_tab(input logic [`NODE_W-1:0] id);
      scpi_pkg::node_t nd;
      nd = '{`ROOT_NODE, '0, 4'h0, 4'h0, 1'b0, `ROOT_NODE};
      unique case (id)
         5'h01: nd = '{`ROOT_NODE, KEYW'("SOURCE"), 4'h6, 4'h4, 1'b0, `ROOT_NODE};
         5'h02: nd = '{5'h01, KEYW'("VOLTAGE"), 4'h7, 4'h4, 1'b0, 5'h03};
         5'h03: nd = '{5'h02, KEYW'("LEVEL"), 4'h5, 4'h3, 1'b1, `ROOT_NODE};
         5'h04: nd = '{5'h02, KEYW'("RANGE"), 4'h5, 4'h4, 1'b1, `ROOT_NODE};
         5'h05: nd = '{5'h01, KEYW'("FREQUENCY"), 4'h9, 4'h4, 1'b1, `ROOT_NODE};
         5'h06: nd = '{5'h01, KEYW'("CURRENT"), 4'h7, 4'h4, 1'b0, 5'h07};
         5'h07: nd = '{5'h06, KEYW'("LEVEL"), 4'h5, 4'h3, 1'b1, `ROOT_NODE};
         5'h08: nd = '{5'h06, KEYW'("PROTECTION"), 4'ha, 4'h4, 1'b0, `ROOT_NODE};
         5'h09: nd = '{5'h08, KEYW'("STATE"), 4'h5, 4'h4, 1'b1, `ROOT_NODE};
         5'h0a: nd = '{5'h08, KEYW'("DELAY"), 4'h5, 4'h3, 1'b1, `ROOT_NODE};
         5'h0b: nd = '{5'h01, KEYW'("FUNCTION"), 4'h8, 4'h4, 1'b1, `ROOT_NODE};
         5'h0c: nd = '{5'h01, KEYW'("PHASE"), 4'h5, 4'h4, 1'b1, `ROOT_NODE};
         5'h0d: nd = '{5'h01, KEYW'("PULSE"), 4'h5, 4'h3, 1'b1, `ROOT_NODE};
         5'h0e: nd = '{5'h01, KEYW'("LIST"), 4'h4, 4'h4, 1'b1, `ROOT_NODE};
         5'h0f: nd = '{`ROOT_NODE, KEYW'("OUTPUT"), 4'h6, 4'h4, 1'b0, 5'h10};
         5'h10: nd = '{5'h0f, KEYW'("STATE"), 4'h5, 4'h4, 1'b1, `ROOT_NODE};
         5'h11: nd = '{`ROOT_NODE, KEYW'("STATUS"), 4'h6, 4'h4, 1'b0, `ROOT_NODE};
         5'h12: nd = '{5'h11, KEYW'("OPERATION"), 4'h9, 4'h4, 1'b1, `ROOT_NODE};
         5'h13: nd = '{5'h12, KEYW'("CONDITION"), 4'h9, 4'h4, 1'b1, `ROOT_NODE};
         default: nd = '{`ROOT_NODE, '0, 4'h0, 4'h0, 1'b0, `ROOT_NODE};
      endcase
      return nd;
   endfunction : node_tab

   // Long form or leading short form of the keyword
   function automatic logic key_hit(input scpi_pkg::node_t nd, input logic [KEYW-1:0] k,
                                    input logic [3:0] len);
      logic [KEYW-1:0] short_key;
      short_key = nd.key >> {nd.long_len - nd.short_len, 3'h0};
      return (len != 4'h0) && ((len == nd.long_len && k == nd.key) ||
                               (len == nd.short_len && k == short_key));
   endfunction : key_hit

   byte_fifo #(
      .WIDTH (9),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .flush    (dev_clear),
      .wr_data  ({in_eom, in_data}),
      .wr_valid (in_valid),
      .wr_ready (in_ready),
      .rd_data  (fifo_data),
      .rd_valid (fifo_valid),
      .rd_ready (out_ready)
   );

   assign step     = fifo_valid & out_ready;
   assign ch       = fifo_data[7:0];
   assign ch_up    = (ch >= `CH_LOW_A && ch <= `CH_LOW_Z) ? (ch & ~`CASE_BIT) : ch;
   assign is_term  = fifo_data[8] | (ch == `CH_NL);
   assign is_delim = (ch == `CH_COLON) | (ch == `CH_SPACE) | (ch == `CH_QUERY) |
                     (ch == `CH_SEMI) | (ch == `CH_NL);

   // Header as it stands with the current character appended
   always_comb begin
      key_now = key_reg;
      len_now = len_reg;
      if (state_reg == scpi_pkg::ST_HEADER && !is_delim && len_reg != 4'(`KEY_CHARS)) begin
         key_now = {key_reg[KEYW-9:0], ch_up};
         len_now = len_reg + 4'h1;
      end
   end

   // Lookup among children of the path node, and at root also among children of the source node
   always_comb begin
      match_ok = 1'b0;
      match_id = `ROOT_NODE;
      scan_nd  = node_tab(`ROOT_NODE);
      for (int i = `NODE_COUNT-1; i >= 1; i--) begin
         scan_nd = node_tab(`NODE_W'(i));
         if ((scan_nd.parent == path_reg ||
              (path_reg == `ROOT_NODE && scan_nd.parent == `SRC_NODE)) &&
             key_hit(scan_nd, key_now, len_now)) begin
            match_ok = 1'b1;
            match_id = `NODE_W'(i);
         end
      end
   end

   assign last_id = (state_reg == scpi_pkg::ST_HEADER) ? match_id : last_reg;
   assign last_nd = node_tab(last_id);
   assign exec_id = (last_nd.dflt != `ROOT_NODE) ? last_nd.dflt : last_id;
   assign exec_ok = (last_nd.dflt != `ROOT_NODE) || last_nd.exec;
   assign hdr_ok  = (state_reg == scpi_pkg::ST_PARAM) || match_ok;

   always_comb begin
      state_next     = state_reg;
      path_next      = path_reg;
      key_next       = key_reg;
      len_next       = len_reg;
      last_next      = last_reg;
      query_next     = query_reg;
      common_next    = common_reg;
      pseen_next     = pseen_reg;
      msg_start_next = msg_start_reg;
      emit           = 1'b0;
      err            = 1'b0;
      qint           = 1'b0;
      pemit          = 1'b0;
      if (step) begin
         if (msg_start_reg && ch != `CH_NL) begin
            qint           = resp_pending;
            msg_start_next = 1'b0;
         end
         if (ch[7]) begin
            err = (state_reg != scpi_pkg::ST_SKIP);
         end else begin
            unique case (state_reg)
               scpi_pkg::ST_START: begin
                  if (ch == `CH_COLON) begin
                     path_next  = `ROOT_NODE;
                     state_next = scpi_pkg::ST_HEADER;
                  end else if (ch == `CH_STAR) begin
                     common_next = 1'b1;
                     state_next  = scpi_pkg::ST_HEADER;
                  end else if (ch == `CH_QUERY) begin
                     err = 1'b1;
                  end else if (!is_delim) begin
                     key_next   = KEYW'(ch_up);
                     len_next   = 4'h1;
                     state_next = scpi_pkg::ST_HEADER;
                  end
               end
               scpi_pkg::ST_HEADER: begin
                  if (!is_delim) begin
                     err      = (len_reg == 4'(`KEY_CHARS));
                     key_next = key_now;
                     len_next = len_now;
                  end else if (ch == `CH_COLON) begin
                     if (common_reg || !match_ok) begin
                        err = 1'b1;
                     end else begin
                        path_next = match_id;
                        key_next  = '0;
                        len_next  = 4'h0;
                     end
                  end else if (ch == `CH_SPACE || ch == `CH_QUERY) begin
                     if (!common_reg && !match_ok) begin
                        err = 1'b1;
                     end else begin
                        last_next  = match_id;
                        query_next = (ch == `CH_QUERY);
                        state_next = scpi_pkg::ST_PARAM;
                     end
                  end
               end
               scpi_pkg::ST_PARAM: begin
                  if (!(ch == `CH_SEMI || ch == `CH_NL || (ch == `CH_SPACE && !pseen_reg))) begin
                     pemit      = 1'b1;
                     pseen_next = 1'b1;
                  end
               end
               scpi_pkg::ST_SKIP: begin
               end
            endcase
            // Unit ends at a semicolon or the terminator
            if (!err && (ch == `CH_SEMI || is_term) &&
                (state_reg == scpi_pkg::ST_HEADER || state_reg == scpi_pkg::ST_PARAM)) begin
               if (common_reg) begin
                  emit = 1'b1;
               end else if (hdr_ok && exec_ok) begin
                  emit      = 1'b1;
                  path_next = last_nd.parent;
               end else begin
                  err = 1'b1;
               end
               state_next  = scpi_pkg::ST_START;
               key_next    = '0;
               len_next    = 4'h0;
               query_next  = 1'b0;
               common_next = 1'b0;
               pseen_next  = 1'b0;
            end
         end
         if (err) begin
            state_next  = scpi_pkg::ST_SKIP;
            query_next  = 1'b0;
            common_next = 1'b0;
            pseen_next  = 1'b0;
         end
         if (is_term) begin
            state_next     = scpi_pkg::ST_START;
            path_next      = `ROOT_NODE;
            key_next       = '0;
            len_next       = 4'h0;
            query_next     = 1'b0;
            common_next    = 1'b0;
            pseen_next     = 1'b0;
            msg_start_next = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || dev_clear) begin
         state_reg     <= scpi_pkg::ST_START;
         path_reg      <= `ROOT_NODE;
         msg_start_reg <= 1'b1;
      end else begin
         state_reg     <= state_next;
         path_reg      <= path_next;
         msg_start_reg <= msg_start_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || dev_clear) begin
         key_reg    <= '0;
         len_reg    <= 4'h0;
         last_reg   <= `ROOT_NODE;
         query_reg  <= 1'b0;
         common_reg <= 1'b0;
         pseen_reg  <= 1'b0;
      end else begin
         key_reg    <= key_next;
         len_reg    <= len_next;
         last_reg   <= last_next;
         query_reg  <= query_next;
         common_reg <= common_next;
         pseen_reg  <= pseen_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || dev_clear) begin
         unit_valid        <= 1'b0;
         unit_node         <= `ROOT_NODE;
         unit_query        <= 1'b0;
         unit_common       <= 1'b0;
         unit_key          <= 32'h0000_0000;
         param_valid       <= 1'b0;
         param_data        <= 8'h00;
         msg_end           <= 1'b0;
         cmd_error         <= 1'b0;
         query_interrupted <= 1'b0;
         path_node         <= `ROOT_NODE;
      end else begin
         unit_valid        <= emit;
         if (emit) begin
            unit_node   <= common_reg ? `ROOT_NODE : exec_id;
            unit_query  <= query_reg;
            unit_common <= common_reg;
            unit_key    <= key_now[31:0];
         end
         param_valid       <= pemit;
         if (pemit) begin
            param_data <= ch;
         end
         msg_end           <= step & is_term;
         cmd_error         <= err;
         query_interrupted <= qint;
         path_node         <= path_next;
      end
   end

   property p_term_root;
      @(posedge sys_clk) disable iff (rst)
      (step && is_term) |=> (path_node == `ROOT_NODE && state_reg == scpi_pkg::ST_START);
   endproperty
   a_term_root: assert property (p_term_root) else $error("Path not at root after terminator");

   property p_root_spec;
      @(posedge sys_clk) disable iff (rst || dev_clear)
      (step && !is_term && state_reg == scpi_pkg::ST_START && ch == `CH_COLON)
      |=> (path_node == `ROOT_NODE) ##1
         (state_reg == scpi_pkg::ST_HEADER || msg_end || cmd_error);
   endproperty
   a_root_spec: assert property (p_root_spec) else $error("Root specifier not honoured");

   property p_common_path;
      @(posedge sys_clk) disable iff (rst)
      (unit_valid && unit_common && !msg_end) |-> $stable(path_node);
   endproperty
   a_common_path: assert property (p_common_path) else $error("Common unit moved path");

   property p_unit_path;
      @(posedge sys_clk) disable iff (rst)
      (unit_valid && !unit_common && !msg_end) |->
         (path_node == node_tab(unit_node).parent ||
          path_node == node_tab(node_tab(unit_node).parent).parent);
   endproperty
   a_unit_path: assert property (p_unit_path) else $error("Path not at parent level");

   property p_error_skip;
      @(posedge sys_clk) disable iff (rst || dev_clear)
      (cmd_error && !msg_end) |-> (state_reg == scpi_pkg::ST_SKIP) ##1
         (state_reg == scpi_pkg::ST_SKIP || msg_end);
   endproperty
   a_error_skip: assert property (p_error_skip) else $error("Error did not skip");

   property p_query_int;
      @(posedge sys_clk) disable iff (rst)
      query_interrupted |-> ($past(resp_pending) && $past(step) && !unit_valid);
   endproperty
   a_query_int: assert property (p_query_int) else $error("Spurious query interrupt");

   property p_upper;
      @(posedge sys_clk) disable iff (rst || dev_clear)
      (step && !is_term && state_reg == scpi_pkg::ST_START && ch >= `CH_LOW_A &&
       ch <= `CH_LOW_Z) |=> (key_reg[7:0] == ($past(ch) - 8'h20) && len_reg == 4'h1);
   endproperty
   a_upper: assert property (p_upper) else $error("Header letter not folded");

   property p_query_mark;
      @(posedge sys_clk) disable iff (rst || dev_clear)
      (step && !is_term && state_reg == scpi_pkg::ST_HEADER && ch == `CH_QUERY && !err)
      |=> (query_reg && state_reg == scpi_pkg::ST_PARAM);
   endproperty
   a_query_mark: assert property (p_query_mark) else $error("Query mark not recorded");

   property p_split;
      @(posedge sys_clk) disable iff (rst || dev_clear)
      (step && ch == `CH_SEMI && state_reg == scpi_pkg::ST_PARAM && exec_ok) |=> unit_valid;
   endproperty
   a_split: assert property (p_split) else $error("Unit not emitted at semicolon");

   property p_ascii;
      @(posedge sys_clk) disable iff (rst || dev_clear)
      (step && ch[7] && state_reg != scpi_pkg::ST_SKIP) |=> (cmd_error && !unit_valid);
   endproperty
   a_ascii: assert property (p_ascii) else $error("Non ASCII byte accepted");
endmodule : scpi_header_path_parser

// *** sim/msg_sender.sv ***
// Remote controller model sending program messages one character at a time
`timescale 1ns/10ps
module msg_sender (
   input  wire logic       sys_clk,
   input  wire logic       in_ready,
   output logic [7:0]      in_data = 8'h00,
   output logic            in_eom = 1'b0,
   output logic            in_valid = 1'b0
);
   bit stuck = 1'b0;
   // Holds each character until taken, then parks the data lines inverted
   task automatic send(input string s, input bit eom);
      int n;
      for (int i = 0; i < s.len(); i++) begin
         @(negedge sys_clk);
         in_data = s[i];
         in_eom = eom && (i == s.len() - 1);
         in_valid = 1'b1;
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (in_ready !== 1'b1 && n < 300);
         if (n >= 300) stuck = 1'b1;
      end
      @(negedge sys_clk);
      in_valid = 1'b0;
      in_eom = 1'b0;
      in_data = ~in_data;
   endtask : send
endmodule : msg_sender

// *** sim/tb_top.sv ***
// Self-checking bench of the header path parser
`timescale 1ns/10ps
`include "scpi_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t value mismatch", $time); end end
module tb_top;
   logic                sys_clk = 1'b0;
   logic                rst = 1'b1;
   logic                dev_clear = 1'b0;
   logic                resp_pending = 1'b0;
   logic                out_ready = 1'b1;
   logic                in_eom, in_valid, in_ready, unit_valid, unit_query, unit_common;
   logic                param_valid, msg_end, cmd_error, query_interrupted;
   logic [7:0]          in_data, param_data;
   logic [`NODE_W-1:0]  unit_node, path_node;
   logic [31:0]         unit_key;
   int                  error_cnt = 0;
   int                  tests_run = 0;
   bit                  rnd_en = 1'b0;
   bit                  park = 1'b1;
   logic [8:0]          exq[$];
   logic [7:0]          pq[$];
   localparam logic [8:0] Q = 9'h040, C = 9'h020, ED = 9'h080, ER = 9'h100, QI = 9'h180;
   scpi_header_path_parser i_scpi_header_path_parser (.sys_clk, .rst, .in_data, .in_eom,
      .in_valid, .in_ready, .dev_clear, .resp_pending, .out_ready, .unit_valid, .unit_node,
      .unit_query, .unit_common, .unit_key, .param_valid, .param_data, .msg_end, .cmd_error,
      .query_interrupted, .path_node);
   msg_sender i_msg_sender (.sys_clk, .in_ready, .in_data, .in_eom, .in_valid);
   always #4 sys_clk = ~sys_clk;
   always @(negedge sys_clk) out_ready <= rnd_en ? ($urandom_range(3) != 0) : park;
   task automatic results();
      $display("errors %0d compares %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic pop(input logic [8:0] got);
      if (exq.size() == 0) `CHK(got, 9'h1ff)
      else `CHK(got, exq.pop_front())
   endtask : pop
   // Notes expected events and the parameter characters of each unit
   task automatic note(input string s, input logic [8:0] ev[$]);
      bit inpar = 1'b0;
      foreach (ev[i]) exq.push_back(ev[i]);
      for (int i = 0; i < s.len(); i++) begin
         if (s[i] == ";" || s[i] == "\n") inpar = 1'b0;
         else if (inpar) pq.push_back(s[i]);
         else if (s[i] == " ") inpar = 1'b1;
      end
   endtask : note
   task automatic idle();
      int n = 0;
      while ((exq.size() != 0 || pq.size() != 0) && n < 500) begin
         @(negedge sys_clk);
         n++;
      end
      repeat (4) @(negedge sys_clk);
      if (n >= 500 || i_msg_sender.stuck) begin
         error_cnt++;
         results();
      end
   endtask : idle
   task automatic msg(input string s, input bit eom, input logic [8:0] ev[$]);
      note(s, ev);
      i_msg_sender.send(s, eom);
      idle();
   endtask : msg
   always @(negedge sys_clk) begin
      if (rst === 1'b0) begin
         if (query_interrupted === 1'b1) pop(QI);
         if (cmd_error === 1'b1) pop(ER);
         if (unit_valid === 1'b1) pop({2'b00, unit_query, unit_common, unit_node});
         if (msg_end === 1'b1) pop(ED);
         if (msg_end === 1'b1) `CHK(path_node, `ROOT_NODE)
         if (param_valid === 1'b1) `CHK(param_data, pq.size() ? pq.pop_front() : 8'hff)
      end
   end
   initial begin
      void'($urandom(32'h60a4));
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      repeat (3) @(negedge sys_clk);
      `CHK(path_node, `ROOT_NODE)
      msg($sformatf("VOLT %c\n", 8'h30 + $urandom_range(9)), 0, {9'h003, ED});
      rnd_en = 1'b1;
      msg("SOUR:VOLT:RANG 156;LEV 115\n", 0, {9'h004, 9'h003, ED});
      msg("VOLT 115;FREQ 60\n", 0, {9'h003, 9'h005, ED});
      msg("voltage:LEVel 8;rAnG 156\n", 0, {9'h003, 9'h004, ED});
      msg("OUTP on;:STAT:OPER:COND?\n", 0, {9'h010, Q | 9'h013, ED});
      msg("CURR:PROT:DEL .1;*TRG;DEL 2\n", 0, {9'h00a, C, 9'h00a, ED});
      msg("VOLT:LEV? MAX\n", 0, {Q | 9'h003, ED});
      msg("PUL 1;PHAS 2;LIST 3;FUNC 4\n", 0, {9'h00d, 9'h00c, 9'h00e, 9'h00b, ED});
      msg("VOLT:LEV 1;FREQ\n", 0, {9'h003, ER, ED});
      msg("\301VOLT\n", 0, {ER, ED});
      msg("VOLT 3", 1, {9'h003, ED});
      msg("CURR 2\n", 1, {9'h007, ED});
      resp_pending = 1'b1;
      msg("*IDN?\n", 0, {QI, Q | C, ED});
      resp_pending = 1'b0;
      `CHK(unit_key, 32'h0049444e)
      msg("VOLT:LEV 1;", 0, {9'h003});
      `CHK(path_node, 5'h02)
      dev_clear = 1'b1;
      @(negedge sys_clk);
      dev_clear = 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(path_node, `ROOT_NODE)
      msg("RANG\n", 0, {ER, ED});
      rnd_en = 1'b0;
      park = 1'b0;
      note("VOLT 12345678901234567890123456\n", {9'h003, ED});
      i_msg_sender.send("VOLT 12345678901234567890123456\n", 0);
      repeat (2) @(negedge sys_clk);
      `CHK(in_ready, 1'b0)
      park = 1'b1;
      idle();
      results();
   end
endmodule : tb_top
